// [core/gid_pkg.sv]
// Package of constants for the glare immunity detector
package gid_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_THRESHOLD = 8'h00;
    localparam logic [7:0] ADDR_CONTROL   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS    = 8'h10;
    // Control field positions
    localparam int CTRL_DEB_HI   = 7;
    localparam int CTRL_DEB_LO   = 4;
    localparam int CTRL_AJAM_BIT = 3;
    localparam int CTRL_FLAG_BIT = 0;
    // Interrupt status bit positions
    localparam int IRQ_EVENT_BIT = 0;
    localparam int IRQ_JAM_BIT   = 1;
    localparam int IRQ_WIDTH     = 2;
    // Reset values and the disabling threshold
    localparam logic [7:0] THRESHOLD_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST   = 8'h00;
    localparam logic [7:0] DISABLE_VALUE = 8'h00;
    // Anti-jam figures
    localparam int JAM_EVENTS       = 12;
    localparam int CLK_MHZ          = 200;
    localparam int WINDOW_US        = 1000;
    localparam int QUIET_US         = 5000;
    localparam int WINDOW_CYCLES    = WINDOW_US * CLK_MHZ;
    localparam int QUIET_CYCLES     = QUIET_US * CLK_MHZ;
    localparam int TIMER_W          = 32;
endpackage : gid_pkg

// [core/gid_debounce.sv]
// Consecutive exceedance counter producing glare events
`timescale 1ns/100ps
`default_nettype none
module gid_debounce #(
    parameter int SAMPLE_W = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample,
    input  wire logic [7:0]          threshold,
    input  wire logic [3:0]          debounce,
    output logic                     event_pulse
);
    // Compare at the wider of sample and threshold
    localparam int CMP_W = (SAMPLE_W > 8) ? SAMPLE_W : 8;

    logic [3:0] run_reg;
    logic       above;
    logic       enabled;

    // Disabled at zero threshold; strict compare
    assign enabled = (threshold != gid_pkg::DISABLE_VALUE);
    assign above   = (CMP_W'(sample) > CMP_W'(threshold));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg     <= 4'h0;
            event_pulse <= 1'b0;
        end else if (ce) begin
            event_pulse <= 1'b0;
            if (sample_valid) begin
                if (!enabled || !above) begin
                    run_reg <= 4'h0;
                end else if ({1'b0, run_reg} + 5'h01 >= {1'b0, debounce}) begin // No wrap at 15
                    // Saturated run keeps firing each sample
                    run_reg     <= debounce;
                    event_pulse <= 1'b1;
                end else begin
                    run_reg <= run_reg + 4'h1;
                end
            end
        end
    end

    // Event needs an exceeding sample
    property p_event_cause;
        @(posedge pclk) disable iff (!presetn)
        $rose(event_pulse) |-> $past(sample_valid && enabled && above);
    endproperty
    a_event_cause: assert property (p_event_cause) else $error("event without cause");

    property p_low_clears;
        @(posedge pclk) disable iff (!presetn)
        (ce && sample_valid && !above) |=> (run_reg == 4'h0) && !event_pulse;
    endproperty
    a_low_clears: assert property (p_low_clears) else $error("run not cleared");
endmodule : gid_debounce
`default_nettype wire

// [core/gid_antijam.sv]
// Anti-jam burst detector with quiet-period recovery
`timescale 1ns/100ps
`default_nettype none
module gid_antijam #(
    parameter int WINDOW_CYCLES = gid_pkg::WINDOW_CYCLES,
    parameter int QUIET_CYCLES  = gid_pkg::QUIET_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic event_in,
    output logic      jammed
);
    typedef enum {GID_WATCH, GID_IGNORE} gid_aj_t;
    gid_aj_t                       state_reg;
    logic [3:0]                    count_reg;
    logic [gid_pkg::TIMER_W-1:0]   timer_reg;

    // Count events within window, quiet exit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= GID_WATCH;
            count_reg <= 4'h0;
            timer_reg <= '0;
        end else if (ce) begin
            if (!enable) begin
                state_reg <= GID_WATCH;
                count_reg <= 4'h0;
                timer_reg <= '0;
            end else begin
                case (state_reg)
                    GID_WATCH: begin
                        if (event_in) begin
                            if (count_reg != 4'h0 &&
                                timer_reg >= gid_pkg::TIMER_W'(WINDOW_CYCLES - 1)) begin
                                // Window ran out: this event opens a new burst
                                count_reg <= 4'h1;
                                timer_reg <= '0;
                            end else if (count_reg == 4'(gid_pkg::JAM_EVENTS - 1)) begin
                                // Quiet span counted from this event
                                state_reg <= GID_IGNORE;
                                count_reg <= 4'h0;
                                timer_reg <= '0;
                            end else begin
                                count_reg <= count_reg + 4'h1;
                                // Window restarts at burst start only
                                if (count_reg == 4'h0)
                                    timer_reg <= '0;
                                else
                                    timer_reg <= timer_reg + 1'b1;
                            end
                        end else if (count_reg != 4'h0) begin
                            if (timer_reg >= gid_pkg::TIMER_W'(WINDOW_CYCLES - 1)) begin
                                count_reg <= 4'h0;
                                timer_reg <= '0;
                            end else begin
                                timer_reg <= timer_reg + 1'b1;
                            end
                        end
                    end
                    GID_IGNORE: begin
                        // Any event restarts the quiet period
                        if (event_in) begin
                            timer_reg <= '0;
                        end else if (timer_reg >= gid_pkg::TIMER_W'(QUIET_CYCLES - 1)) begin
                            state_reg <= GID_WATCH;
                            timer_reg <= '0;
                        end else begin
                            timer_reg <= timer_reg + 1'b1;
                        end
                    end
                    default: state_reg <= GID_WATCH;
                endcase
            end
        end
    end

    assign jammed = (state_reg == GID_IGNORE);

    property p_jam_needs_enable;
        @(posedge pclk) disable iff (!presetn)
        $rose(jammed) |-> $past(enable && event_in && count_reg == 4'hB);
    endproperty
    a_jam_needs_enable: assert property (p_jam_needs_enable) else $error("bad jam entry");

    property p_quiet_exit;
        @(posedge pclk) disable iff (!presetn)
        $fell(jammed) && $past(enable) |-> $past(!event_in);
    endproperty
    a_quiet_exit: assert property (p_quiet_exit) else $error("exit during glare");
endmodule : gid_antijam
`default_nettype wire

// [core/gid_top.sv]
// Glare immunity detector top with APB registers and interrupt
`timescale 1ns/100ps
`default_nettype none
module gid_top #(
    parameter int SAMPLE_W      = 8,
    parameter int WINDOW_CYCLES = gid_pkg::WINDOW_CYCLES,
    parameter int QUIET_CYCLES  = gid_pkg::QUIET_CYCLES
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample,
    output logic                     motion_inhibit,
    output logic                     irq
);
    logic [7:0]                    threshold_reg;
    logic [7:0]                    control_reg;
    logic [gid_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
    logic [gid_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
    logic                          event_raw;
    logic                          jammed;
    logic                          jammed_d_reg;
    logic                          glare_event;
    logic                          wr_en;
    logic                          rd_en;
    logic                          hit;
    logic                          lane0;
    logic [31:0]                   rdata_next;

    // Single-cycle APB; access phase always ready
    assign pready = 1'b1;
    assign wr_en  = ce && psel && penable && pwrite;
    assign rd_en  = ce && psel && penable && !pwrite;
    assign lane0  = pstrb[0];

    // Address decode
    always_comb begin
        hit        = 1'b1;
        rdata_next = 32'h0000_0000;
        if (paddr == gid_pkg::ADDR_THRESHOLD) begin
            rdata_next[7:0] = threshold_reg;
        end else if (paddr == gid_pkg::ADDR_CONTROL) begin
            // Reserved bits 2:1 read zero
            rdata_next[7:0] = control_reg;
        end else if (paddr == gid_pkg::ADDR_IRQ_STAT) begin
            rdata_next[gid_pkg::IRQ_WIDTH-1:0] = irq_stat_reg;
        end else if (paddr == gid_pkg::ADDR_IRQ_MASK) begin
            rdata_next[gid_pkg::IRQ_WIDTH-1:0] = irq_mask_reg;
        end else if (paddr == gid_pkg::ADDR_STATUS) begin
            rdata_next[0] = jammed;
            rdata_next[1] = motion_inhibit;
        end else begin
            hit = 1'b0;
        end
    end

    assign pslverr = psel && penable && !hit;

    // Read data registered in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (ce && psel && !penable)
            prdata <= rdata_next;
    end

    // Threshold register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_reg <= gid_pkg::THRESHOLD_RST;
        end else if (wr_en && lane0 && paddr == gid_pkg::ADDR_THRESHOLD) begin
            threshold_reg <= pwdata[7:0];
        end
    end

    gid_debounce #(
        .SAMPLE_W     (SAMPLE_W)
    ) u_debounce (
        .pclk         (pclk),
        .presetn      (presetn),
        .ce           (ce),
        .sample_valid (sample_valid),
        .sample       (sample),
        .threshold    (threshold_reg),
        .debounce     (control_reg[gid_pkg::CTRL_DEB_HI:gid_pkg::CTRL_DEB_LO]),
        .event_pulse  (event_raw)
    );

    gid_antijam #(
        .WINDOW_CYCLES (WINDOW_CYCLES),
        .QUIET_CYCLES  (QUIET_CYCLES)
    ) u_antijam (
        .pclk          (pclk),
        .presetn       (presetn),
        .ce            (ce),
        .enable        (control_reg[gid_pkg::CTRL_AJAM_BIT]),
        .event_in      (event_raw),
        .jammed        (jammed)
    );

    assign glare_event = event_raw && !(control_reg[gid_pkg::CTRL_AJAM_BIT] && jammed);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            motion_inhibit <= 1'b0;
        else if (ce)
            motion_inhibit <= glare_event;
    end

    // Control register; flag written zero clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= gid_pkg::CONTROL_RST;
        end else if (ce) begin
            if (wr_en && lane0 && paddr == gid_pkg::ADDR_CONTROL) begin
                control_reg[7:3] <= pwdata[7:3];
                control_reg[gid_pkg::CTRL_FLAG_BIT] <= pwdata[gid_pkg::CTRL_FLAG_BIT];
            end
            // Event sets flag, wins over clear
            if (glare_event)
                control_reg[gid_pkg::CTRL_FLAG_BIT] <= 1'b1;
        end
    end

    // Edge of jam entry for interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            jammed_d_reg <= 1'b0;
        else if (ce)
            jammed_d_reg <= jammed;
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else if (ce) begin
            if (wr_en && lane0 && paddr == gid_pkg::ADDR_IRQ_STAT)
                irq_stat_reg <= irq_stat_reg & ~pwdata[gid_pkg::IRQ_WIDTH-1:0];
            if (glare_event)
                irq_stat_reg[gid_pkg::IRQ_EVENT_BIT] <= 1'b1;
            if (jammed && !jammed_d_reg)
                irq_stat_reg[gid_pkg::IRQ_JAM_BIT] <= 1'b1;
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_mask_reg <= '0;
        else if (wr_en && lane0 && paddr == gid_pkg::ADDR_IRQ_MASK)
            irq_mask_reg <= pwdata[gid_pkg::IRQ_WIDTH-1:0];
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Flag held unless software writes control
    property p_flag_sticky;
        @(posedge pclk) disable iff (!presetn)
        $fell(control_reg[0]) |-> $past(wr_en && paddr == gid_pkg::ADDR_CONTROL && !glare_event);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hw");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        (ce && glare_event) |=> control_reg[0] && irq_stat_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_inhibit;
        @(posedge pclk) disable iff (!presetn)
        (ce && event_raw && !control_reg[3]) |=> motion_inhibit;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("no inhibit");

    property p_jam_blocks;
        @(posedge pclk) disable iff (!presetn)
        (ce && jammed && control_reg[3]) |=> !motion_inhibit;
    endproperty
    a_jam_blocks: assert property (p_jam_blocks) else $error("jammed still inhibits");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        (threshold_reg == 8'h00) [*3] |-> !event_raw;
    endproperty
    a_disabled: assert property (p_disabled) else $error("event while disabled");

    property p_no_jam_off;
        @(posedge pclk) disable iff (!presetn)
        (ce && !control_reg[3]) |=> !jammed;
    endproperty
    a_no_jam_off: assert property (p_no_jam_off) else $error("jam while off");

    // Strobes seen by the checks below
    logic thr_wr;
    logic ctrl_wr;
    logic stat_wr;
    logic setup_ph;
    assign thr_wr   = wr_en && lane0 && (paddr == gid_pkg::ADDR_THRESHOLD);
    assign ctrl_wr  = wr_en && lane0 && (paddr == gid_pkg::ADDR_CONTROL);
    assign stat_wr  = wr_en && lane0 && (paddr == gid_pkg::ADDR_IRQ_STAT);
    assign setup_ph = ce && psel && !penable;

    property p_thr_write;
        @(posedge pclk) disable iff (!presetn)
        thr_wr |=> (threshold_reg == $past(pwdata[7:0]));
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

    property p_thr_hold;
        @(posedge pclk) disable iff (!presetn)
        !thr_wr |=> $stable(threshold_reg);
    endproperty
    a_thr_hold: assert property (p_thr_hold) else $error("threshold changed");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> (control_reg[7:3] == $past(pwdata[7:3]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_flag_rise;
        @(posedge pclk) disable iff (!presetn)
        $rose(control_reg[0]) |-> $past(glare_event || ctrl_wr);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag set without cause");

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_wr && !pwdata[0] && !glare_event) |=> !control_reg[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

    property p_flag_wins;
        @(posedge pclk) disable iff (!presetn)
        (ctrl_wr && glare_event) |=> control_reg[0];
    endproperty
    a_flag_wins: assert property (p_flag_wins) else $error("clear beat event");

    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        (control_reg[0] && !ctrl_wr) |=> control_reg[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_inhibit_cause;
        @(posedge pclk) disable iff (!presetn)
        (motion_inhibit && $past(ce)) |-> $past(glare_event);
    endproperty
    a_inhibit_cause: assert property (p_inhibit_cause) else $error("inhibit without event");

    property p_quiet_inhibit;
        @(posedge pclk) disable iff (!presetn)
        (ce && !event_raw) |=> !motion_inhibit;
    endproperty
    a_quiet_inhibit: assert property (p_quiet_inhibit) else $error("stray inhibit");

    property p_jam_pass;
        @(posedge pclk) disable iff (!presetn)
        (ce && event_raw && control_reg[3] && !jammed) |=> motion_inhibit;
    endproperty
    a_jam_pass: assert property (p_jam_pass) else $error("event lost before jam");

    property p_jam_irq;
        @(posedge pclk) disable iff (!presetn)
        (ce && jammed && !jammed_d_reg) |=> irq_stat_reg[gid_pkg::IRQ_JAM_BIT];
    endproperty
    a_jam_irq: assert property (p_jam_irq) else $error("jam status not set");

    property p_stat_clear;
        @(posedge pclk) disable iff (!presetn)
        (stat_wr && pwdata[0] && !glare_event) |=> !irq_stat_reg[0];
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status clear lost");

    property p_stat_hold;
        @(posedge pclk) disable iff (!presetn)
        (irq_stat_reg[0] && !stat_wr) |=> irq_stat_reg[0];
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("status dropped");

    property p_rd_thr;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && paddr == gid_pkg::ADDR_THRESHOLD) |=> (prdata[7:0] == $past(threshold_reg));
    endproperty
    a_rd_thr: assert property (p_rd_thr) else $error("threshold read wrong");

    property p_rd_ctrl;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && paddr == gid_pkg::ADDR_CONTROL) |=> (prdata[7:0] == $past(control_reg));
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

    // Low enable freezes registers
    property p_freeze;
        @(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(threshold_reg) && $stable(control_reg) && $stable(irq_stat_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    // Mask write lands
    property p_mask_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && lane0 && paddr == gid_pkg::ADDR_IRQ_MASK)
            |=> (irq_mask_reg == $past(pwdata[gid_pkg::IRQ_WIDTH-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    // Access past the map is refused
    property p_slverr;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && paddr > gid_pkg::ADDR_STATUS) |-> pslverr;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
endmodule : gid_top
`default_nettype wire

// [tb/gid_sample_src.sv]
// Sample source model standing in for the infrared front end
`timescale 1ns/100ps
`default_nettype none
module gid_sample_src (
    input  wire logic  pclk,
    output logic       sample_valid,
    output logic [7:0] sample
);
    logic [7:0] last_val;

    // Quiet at time zero
    initial begin
        sample_valid = 1'b0;
        sample       = 8'h00;
        last_val     = 8'h00;
    end

    // Back-to-back samples; idle value inverted so stale data never looks valid
    task automatic send(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            sample_valid <= 1'b1;
            sample       <= v;
        end
        last_val = v;
        @(posedge pclk);
        sample_valid <= 1'b0;
        sample       <= ~last_val;
    endtask : send
endmodule : gid_sample_src
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the glare immunity detector
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int WIN   = 50;
    localparam int QUIET = 100;

    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sample_valid;
    logic [7:0]  sample;
    logic        motion_inhibit;
    logic        irq;
    logic [31:0] ev_cnt;
    logic [31:0] rdat;
    logic        rerr;
    int          fails;
    int          cmp_count;

    // Short window and quiet span keep the anti-jam run brief
    gid_top #(.SAMPLE_W(8), .WINDOW_CYCLES(WIN), .QUIET_CYCLES(QUIET)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .sample(sample),
        .motion_inhibit(motion_inhibit), .irq(irq)
    );

    gid_sample_src src (.pclk(pclk), .sample_valid(sample_valid), .sample(sample));

    // Clock at 200 MHz
    always #2.5 pclk = ~pclk;

    // Count cycles with inhibit high; one per event
    always @(posedge pclk) begin
        if (motion_inhibit === 1'b1) ev_cnt <= ev_cnt + 32'h1;
    end

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; holds everything until pready is seen high
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd

    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask : settle

    // Watchdog well beyond the expected run
    initial begin
        #100000;
        fails++;
        conclude();
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; ev_cnt = 32'h0;
        pstrb = 4'hF;
        fails = 0; cmp_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and the unmapped place
        rd(gid_pkg::ADDR_THRESHOLD, 32'h0);
        rd(gid_pkg::ADDR_CONTROL, 32'h0);
        rd(gid_pkg::ADDR_STATUS, 32'h0);
        rd(8'h14, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(gid_pkg::ADDR_THRESHOLD, 32'hA5);
        rd(gid_pkg::ADDR_THRESHOLD, 32'hA5);
        // Frozen clock enable drops the write
        @(posedge pclk);
        ce <= 1'b0;
        wr(gid_pkg::ADDR_THRESHOLD, 32'h11);
        ce <= 1'b1;
        rd(gid_pkg::ADDR_THRESHOLD, 32'hA5);
        chk({31'h0, rerr}, 32'h0);
        // Write with the low lane off is dropped
        pstrb <= 4'hE;
        wr(gid_pkg::ADDR_THRESHOLD, 32'h22);
        pstrb <= 4'hF;
        rd(gid_pkg::ADDR_THRESHOLD, 32'hA5);
        // Zero threshold gives no events at all
        wr(gid_pkg::ADDR_CONTROL, 32'h10);
        wr(gid_pkg::ADDR_THRESHOLD, 32'h00);
        src.send(8'hFF, 10);
        settle();
        chk(ev_cnt, 32'h0);
        rd(gid_pkg::ADDR_CONTROL, 32'h10);
        // Equal sample breaks the run of three
        wr(gid_pkg::ADDR_THRESHOLD, 32'h80);
        wr(gid_pkg::ADDR_CONTROL, 32'h30);
        src.send(8'h81, 2);
        src.send(8'h80, 1);
        src.send(8'h81, 2);
        settle();
        chk(ev_cnt, 32'h0);
        src.send(8'h81, 1);
        settle();
        chk(ev_cnt, 32'h1);
        rd(gid_pkg::ADDR_CONTROL, 32'h31);
        settle();
        rd(gid_pkg::ADDR_CONTROL, 32'h31);
        wr(gid_pkg::ADDR_CONTROL, 32'h30);
        rd(gid_pkg::ADDR_CONTROL, 32'h30);
        // Interrupt raised, masked, cleared
        rd(gid_pkg::ADDR_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(gid_pkg::ADDR_IRQ_MASK, 32'h1);
        rd(gid_pkg::ADDR_IRQ_MASK, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(gid_pkg::ADDR_IRQ_STAT, 32'h1);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(gid_pkg::ADDR_IRQ_MASK, 32'h2);
        // Without anti-jam every sample above fires
        wr(gid_pkg::ADDR_CONTROL, 32'h10);
        src.send(8'h90, 20);
        settle();
        chk(ev_cnt, 32'd21);
        rd(gid_pkg::ADDR_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(gid_pkg::ADDR_IRQ_STAT, 32'h3);
        // Anti-jam: twelve pass, the rest ignored, quiet span restores
        wr(gid_pkg::ADDR_CONTROL, 32'h18);
        rd(gid_pkg::ADDR_CONTROL, 32'h18);
        src.send(8'h90, 15);
        settle();
        chk(ev_cnt, 32'd21 + gid_pkg::JAM_EVENTS);
        rd(gid_pkg::ADDR_STATUS, 32'h1);
        rd(gid_pkg::ADDR_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h1);
        repeat (QUIET + 20) @(posedge pclk);
        rd(gid_pkg::ADDR_STATUS, 32'h0);
        src.send(8'h90, 1);
        settle();
        chk(ev_cnt, 32'd22 + gid_pkg::JAM_EVENTS);
        conclude();
    end
endmodule : testbench
`default_nettype wire
